// file: core/fpc_top.sv
// Purpose: program-memory self-programming, lock and serial download control
// Assumes: mclk 10 MHz; sck from the programmer is a second clock domain
// Notes:   flash, page buffer and eeprom are modelled with fpc_mem instances
//
// Summary of operation
// RL1: two boot lock sets, set independently
// RL2: four protection levels for software updates; the code has one lock bit per section, locked or open
// RL3: locks set by software/serial; chip erase clears
// RL4: general write lock ignored by store instruction
// RL5: general read/write lock ignored by load/store
// RL6: page update; erase before write from buffer
// RL7: buffer loads one word, before or after erase
// RL8: buffer words writable in any order
// RL9: software uses same page for erase and write
// RL10: fill-first keeps old data readable until erase
// RL11: calibration byte read via parallel command 0x08
// RL12: serial programming only while reset held low
// RL13: program enable required before program or erase
// RL14: serial eeprom write auto-erases the location
// RL15: chip erase sets every location to 0xFF
// RL16: programmer keeps sck phases over two cycles
// RL17: serial data captured on rising sck
// RL18: valid core clock needed during serial programming
// RL19: done flag marks end of erase and write
`timescale 1ns/10ps
module fpc_top
	import fpc_pkg::*;
#(
	parameter int PAGE_AW = 3,
	parameter int PAGE_N  = 8,
	parameter int EE_AW   = 6,
	parameter logic [7:0] CAL_BYTE = 8'h5A
)
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        reset_pin_n,
	input  wire logic        sck,
	input  wire logic        mosi,
	output logic             miso,
	input  wire logic        par_oe_n,
	input  wire logic        par_byte_select_one,
	input  wire logic [7:0]  par_cmd,
	input  wire logic [7:0]  par_addr_lo,
	output logic      [7:0]  par_data,
	output logic             par_data_oe
);
	localparam int FA = PAGE_AW + $clog2(PAGE_N);

	// ------------------------------------------------------------
	// serial shifter on the programmer's clock
	// ------------------------------------------------------------
	logic [31:0] sh_q;
	logic [4:0]  bit_q;
	logic        frame_tgl_q;
	logic [31:0] frame_q;
	logic [7:0]  out_sh_q;
	logic [7:0]  ser_reply;

	// data sampled on the rising sck edge; frames of 32 bits
	always_ff @(posedge sck)  // see RL17
	begin
		if (reset_pin_n)
		begin
			bit_q       <= 5'h00;
			frame_tgl_q <= 1'b0;
		end
		else
		begin
			sh_q  <= {sh_q[30:0], mosi};
			bit_q <= bit_q + 5'h01;
			if (bit_q == 5'h1F)
			begin
				frame_q     <= {sh_q[30:0], mosi};
				frame_tgl_q <= ~frame_tgl_q;
			end
		end
	end

	// reply byte shifts out on the falling edge during the last byte
	always_ff @(negedge sck)
	begin
		if (bit_q == 5'h18)
			out_sh_q <= ser_reply;
		else
			out_sh_q <= {out_sh_q[6:0], 1'b0};
	end
	assign miso = reset_pin_n ? 1'b0 : out_sh_q[7];  // see RL12

	// ------------------------------------------------------------
	// crossings into mclk
	// ------------------------------------------------------------
	logic [2:0] tgl_sync_q;
	logic [1:0] rst_sync_q;
	logic       frame_ev;
	logic       ser_mode;
	logic [31:0] cmd_q;

	// toggle handshake: frame_q is stable for a whole frame after the toggle
	always_ff @(posedge mclk)  // see RL18
	begin
		tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl_q};
		rst_sync_q <= {rst_sync_q[0], reset_pin_n};
		if (frame_ev)
			cmd_q <= frame_q;
	end
	assign frame_ev = tgl_sync_q[2] ^ tgl_sync_q[1];
	assign ser_mode = ~rst_sync_q[1];  // see RL12

	// ------------------------------------------------------------
	// serial command decode
	// ------------------------------------------------------------
	logic       prog_en_q;
	wire        cmd_go     = frame_ev & ser_mode;
	wire        c_pe       = (frame_q[31:24] == SER_PROG_EN) & (frame_q[23:16] == SER_PE_KEY);
	wire        c_chip     = prog_en_q & (frame_q[31:24] == SER_PROG_EN)
	                         & (frame_q[23:16] == SER_ERASE_B2);  // see RL13
	wire        c_eew      = prog_en_q & (frame_q[31:24] == SER_WR_EE);  // see RL13
	wire        c_lock     = prog_en_q & (frame_q[31:24] == SER_PROG_EN)
	                         & (frame_q[23:16] == 8'hE0);
	wire        c_rd_cal   = frame_q[31:24] == SER_RD_CAL;

	// enable is lost whenever reset is released
	always_ff @(posedge mclk)
	begin
		if (rst | ~ser_mode)
			prog_en_q <= 1'b0;
		else if (cmd_go & c_pe)
			prog_en_q <= 1'b1;  // see RL13
	end

	// ------------------------------------------------------------
	// memories
	// ------------------------------------------------------------
	fpc_state_e  st_q;
	logic [15:0] cnt_q;
	logic [FA-1:0] sweep_q;
	logic [FA-1:0] fl_waddr, fl_raddr;
	logic [15:0] fl_wdata, fl_rdata, pb_rdata;
	logic        fl_we, pb_we, ee_we;
	logic [7:0]  ee_wdata, ee_rdata;
	logic [EE_AW-1:0] ee_waddr;
	logic [PAGE_AW-1:0] page_q;
	logic [$clog2(PAGE_N)-1:0] word_q;
	logic [15:0] wbuf_q;
	logic [EE_AW-1:0] ee_addr_q;
	logic [7:0]  ee_data_q;
	// buffer read is registered, so fetch one slot ahead of the flash write
	wire [$clog2(PAGE_N)-1:0] pb_raddr = (st_q == FPC_WRITE)
	                                   ? sweep_q[$clog2(PAGE_N)-1:0] + $clog2(PAGE_N)'(1)
	                                   : '0;  // see RL6

	fpc_mem #(.AW(FA), .DW(16)) u_flash
	(
		.clk   (mclk),
		.we    (fl_we),
		.waddr (fl_waddr),
		.wdata (fl_wdata),
		.raddr (fl_raddr),
		.rdata (fl_rdata)
	);
	fpc_mem #(.AW($clog2(PAGE_N)), .DW(16)) u_pagebuf
	(
		.clk   (mclk),
		.we    (pb_we),
		.waddr (word_q),
		.wdata (wbuf_q),
		.raddr (pb_raddr),
		.rdata (pb_rdata)
	);
	fpc_mem #(.AW(EE_AW), .DW(8)) u_eeprom
	(
		.clk   (mclk),
		.we    (ee_we),
		.waddr (ee_waddr),
		.wdata (ee_wdata),
		.raddr (cmd_q[EE_AW+7:8]),
		.rdata (ee_rdata)
	);

	// ------------------------------------------------------------
	// software registers and lock state
	// ------------------------------------------------------------
	logic [1:0] lock_q;
	logic       done_q, denied_q;
	logic [2:0] sw_cmd;
	wire        sw_ctrl   = reg_wr & (reg_addr == REG_CTRL);
	wire        idle      = st_q == FPC_IDLE;
	wire        page_boot = page_q[PAGE_AW-1];  // top half of flash is boot
	// only the boot lock of the targeted section matters; general locks never gate
	wire        page_lock = page_boot ? lock_q[LK_BOOT] : lock_q[LK_APP];  // see RL2 RL4 RL5
	wire        go_erase  = sw_ctrl & idle & (sw_cmd == CMD_ERASE) & ~page_lock;
	wire        go_write  = sw_ctrl & idle & (sw_cmd == CMD_WRITE) & ~page_lock;
	wire        go_deny   = sw_ctrl & ((sw_cmd == CMD_ERASE) | (sw_cmd == CMD_WRITE))
	                        & (page_lock | ~idle);
	wire        go_chip   = cmd_go & c_chip & idle;
	wire        go_eew    = cmd_go & c_eew & idle;
	assign sw_cmd = reg_wdata[2:0];

	// address and write-data registers; any word order is fine
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			page_q <= '0;
			word_q <= '0;
			wbuf_q <= 16'h0000;
		end
		else if (reg_wr & (reg_addr == REG_ADDR))
		begin
			page_q <= reg_wdata[FA-1:$clog2(PAGE_N)];
			word_q <= reg_wdata[$clog2(PAGE_N)-1:0];  // see RL8
		end
		else if (reg_wr & (reg_addr == REG_WDATA))
			wbuf_q <= reg_wdata;
	end

	// one word per fill, accepted any time the engine is idle
	assign pb_we = sw_ctrl & idle & (sw_cmd == CMD_FILL);  // see RL7

	// lock bits: set-only by software or serial, cleared by chip erase
	always_ff @(posedge mclk)
	begin
		if (rst)
			lock_q <= LOCK_RESET;
		else if (st_q == FPC_CHIP)
			lock_q <= LOCK_RESET;  // see RL3
		else if (sw_ctrl & (sw_cmd == CMD_LOCK))
			lock_q <= lock_q | reg_wdata[9:8];  // see RL1 RL3
		else if (cmd_go & c_lock)
			lock_q <= lock_q | ~frame_q[1:0];  // see RL1 RL3
	end

	// ------------------------------------------------------------
	// self-timed engine
	// ------------------------------------------------------------
	wire cnt_end = cnt_q == 16'(OP_CYC - 1);
	wire sweep_end = &sweep_q;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_q    <= FPC_IDLE;
			cnt_q   <= 16'h0000;
			sweep_q <= '0;
		end
		else
		begin
			unique case (st_q)
				FPC_IDLE:
				begin
					cnt_q   <= 16'h0000;
					sweep_q <= '0;
					if (go_chip)
						st_q <= FPC_CHIP;
					else if (go_eew)
						st_q <= FPC_EEW;
					else if (go_erase)
						st_q <= FPC_ERASE;  // see RL6
					else if (go_write)
						st_q <= FPC_WRITE;  // see RL6
				end
				FPC_ERASE, FPC_WRITE:
				begin
					sweep_q <= sweep_q + 1'b1;
					if (sweep_q[$clog2(PAGE_N)-1:0] == $clog2(PAGE_N)'(PAGE_N - 1))
						st_q <= FPC_IDLE;
				end
				FPC_CHIP:
				begin
					sweep_q <= sweep_q + 1'b1;
					if (sweep_end)
						st_q <= FPC_IDLE;
				end
				FPC_EEW:
				begin
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_end)
						st_q <= FPC_IDLE;
				end
			endcase
		end
	end

	// flash port: erase writes 0xFF words, page write copies the buffer
	wire [FA-1:0] page_addr = {page_q, sweep_q[$clog2(PAGE_N)-1:0]};
	assign fl_we    = (st_q == FPC_ERASE) | (st_q == FPC_CHIP) | (st_q == FPC_WRITE);
	assign fl_waddr = (st_q == FPC_CHIP) ? sweep_q : page_addr;
	// buffer data line up with the sweep because the read runs one slot ahead
	assign fl_wdata = (st_q == FPC_WRITE) ? pb_rdata : {ERASED_BYTE, ERASED_BYTE};  // see RL15
	// reads see the old page until the erase actually runs
	assign fl_raddr = ser_mode ? cmd_q[FA+7:8] : {page_q, word_q};  // see RL10

	// eeprom: chip erase sweeps to 0xFF; serial write overwrites in one step
	assign ee_we    = (st_q == FPC_CHIP) | ((st_q == FPC_EEW) & cnt_end);
	assign ee_waddr = (st_q == FPC_CHIP) ? sweep_q[EE_AW-1:0] : ee_addr_q;
	assign ee_wdata = (st_q == FPC_CHIP) ? ERASED_BYTE : ee_data_q;  // see RL14 RL15

	// latch serial eeprom target; no separate erase step is needed
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ee_addr_q <= '0;
			ee_data_q <= 8'h00;
		end
		else if (go_eew)
		begin
			ee_addr_q <= frame_q[EE_AW+7:8];
			ee_data_q <= frame_q[7:0];  // see RL14
		end
	end

	// done is sticky until the next erase, write, chip erase or eeprom write starts; completion wins over clear
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			done_q   <= 1'b0;
			denied_q <= 1'b0;
		end
		else
		begin
			if (~idle & (fl_we | ee_we) & ((st_q == FPC_EEW) | sweep_end
			    | (st_q != FPC_CHIP) & (sweep_q[$clog2(PAGE_N)-1:0]
			    == $clog2(PAGE_N)'(PAGE_N - 1))))
				done_q <= 1'b1;  // see RL19
			else if (go_erase | go_write | go_chip | go_eew)
				done_q <= 1'b0;
			if (go_deny)
				denied_q <= 1'b1;
			else if (sw_ctrl)
				denied_q <= 1'b0;
		end
	end

	// serial reply byte: calibration, eeprom read or flash read
	assign ser_reply = c_rd_cal ? CAL_BYTE
	                   : (cmd_q[31:24] == SER_RD_EE) ? ee_rdata
	                   : cmd_q[0] ? fl_rdata[15:8] : fl_rdata[7:0];

	// ------------------------------------------------------------
	// register read port and parallel calibration read
	// ------------------------------------------------------------
	wire [15:0] status_w = {12'h000, prog_en_q, denied_q, done_q, ~idle};
	wire [15:0] rd_mux   = (reg_addr == REG_STATUS) ? status_w
	                     : (reg_addr == REG_RDATA)  ? fl_rdata
	                     : (reg_addr == REG_LOCK)   ? {14'h0000, lock_q}
	                     : (reg_addr == REG_ADDR)   ? 16'({page_q, word_q})
	                     : 16'h0000;
	wire        cal_sel  = (par_cmd == PAR_CMD_CAL) & (par_addr_lo == PAR_ADDR_CAL)
	                       & ~par_oe_n & par_byte_select_one;  // see RL11

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			reg_rdata   <= 16'h0000;
			par_data    <= 8'h00;
			par_data_oe <= 1'b0;
		end
		else
		begin
			reg_rdata   <= reg_rd ? rd_mux : 16'h0000;
			par_data    <= cal_sel ? CAL_BYTE : 8'h00;
			par_data_oe <= cal_sel;
		end
	end
	// RL16 and RL9 are kept by the outside; sck phase limits suit SCK_MIN_CYC
endmodule

// file: core/fpc_pkg.sv
// Purpose: shared constants for the flash programming control block
// Assumes: 16-bit program words, small page buffer, byte-wide eeprom
// Notes:   serial command codes and the register map live here
package fpc_pkg;
	// ------------------------------------------------------------
	// register map (word index on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_ADDR    = 4'h1;
	localparam logic [3:0] REG_WDATA   = 4'h2;
	localparam logic [3:0] REG_STATUS  = 4'h3;
	localparam logic [3:0] REG_RDATA   = 4'h4;
	localparam logic [3:0] REG_LOCK    = 4'h5;
	// control register command codes
	localparam logic [2:0] CMD_NONE    = 3'h0;
	localparam logic [2:0] CMD_FILL    = 3'h1;
	localparam logic [2:0] CMD_ERASE   = 3'h2;
	localparam logic [2:0] CMD_WRITE   = 3'h3;
	localparam logic [2:0] CMD_READ    = 3'h4;
	localparam logic [2:0] CMD_LOCK    = 3'h5;
	// status bit positions
	localparam int ST_BUSY             = 0;
	localparam int ST_DONE             = 1;
	localparam int ST_DENIED           = 2;
	localparam int ST_PROG_EN          = 3;
	// lock field: bit0 protects application, bit1 protects boot
	localparam int LK_APP              = 0;
	localparam int LK_BOOT             = 1;
	localparam logic [1:0] LOCK_RESET  = 2'h0;
	// serial command bytes (opcode in the first byte of a 4-byte frame; key and erase code in the second)
	localparam logic [7:0] SER_PROG_EN  = 8'hAC;
	localparam logic [7:0] SER_PE_KEY   = 8'h53;
	localparam logic [7:0] SER_ERASE_B2 = 8'h80;
	localparam logic [7:0] SER_RD_PROG  = 8'h20;
	localparam logic [7:0] SER_WR_EE    = 8'hC0;
	localparam logic [7:0] SER_RD_EE    = 8'hA0;
	localparam logic [7:0] SER_RD_CAL   = 8'h38;
	// parallel calibration read
	localparam logic [7:0] PAR_CMD_CAL  = 8'h08;
	localparam logic [7:0] PAR_ADDR_CAL = 8'h00;
	// erased state of every memory location
	localparam logic [7:0] ERASED_BYTE  = 8'hFF;
	// timing
	localparam int CLK_HZ               = 10_000_000;
	localparam int SCK_MIN_CYC          = (CLK_HZ < 12_000_000) ? 2 : 3;
	localparam int OP_TIME_US           = 4;
	localparam int OP_CYC               = (OP_TIME_US * (CLK_HZ / 1_000_000) > 0)
	                                      ? OP_TIME_US * (CLK_HZ / 1_000_000) : 1;
	typedef enum logic [2:0] {FPC_IDLE, FPC_ERASE, FPC_WRITE, FPC_CHIP, FPC_EEW} fpc_state_e;
endpackage

// file: core/fpc_mem.sv
// Purpose: small synchronous memory with registered read data
// Assumes: one write port and one read port on the same clock
// Notes:   contents start unknown; a chip erase sets flash and eeprom to 0xFF, a page erase one flash page; the page buffer is never erased
`timescale 1ns/10ps
module fpc_mem
#(
	parameter int AW = 6,
	parameter int DW = 16
)
(
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// read first, read registered: a same-cycle read sees old data
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule

// file: tb/fpc_top_sva.sv
// Purpose: port-level checks for the flash programming control block
// Assumes: one core clock domain, rst synchronous active high
// Notes:   sck is only looked at through the core clock
`timescale 1ns/10ps
module fpc_top_sva
	import fpc_pkg::*;
#(
	parameter logic [7:0] CAL_BYTE = 8'h5A
)
(
	input logic        mclk,
	input logic        rst,
	input logic [3:0]  reg_addr,
	input logic [15:0] reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [15:0] reg_rdata,
	input logic        reset_pin_n,
	input logic        sck,
	input logic        miso,
	input logic        par_oe_n,
	input logic        par_byte_select_one,
	input logic [7:0]  par_cmd,
	input logic [7:0]  par_addr_lo,
	input logic [7:0]  par_data,
	input logic        par_data_oe
);
	// ----------------------------------------------------------
	// properties
	// ----------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// named decodes keep the properties short
	wire st_rd  = reg_rd && reg_addr == REG_STATUS;
	wire cal_rq = !par_oe_n && par_byte_select_one && par_cmd == PAR_CMD_CAL
	              && par_addr_lo == PAR_ADDR_CAL;
	cal_drive_a: assert property (
		cal_rq |=> par_data_oe && par_data == CAL_BYTE) else $error("cal byte not driven");
	cal_release_a: assert property (
		par_oe_n |=> !par_data_oe) else $error("data port held after oe high");
	miso_idle_a: assert property (
		reset_pin_n [*4] |-> !miso) else $error("miso active outside programming");
	miso_edge_a: assert property (
		!reset_pin_n && $changed(miso) |-> !sck) else $error("miso moved while sck high");
	pe_clear_a: assert property (
		reset_pin_n [*4] ##0 st_rd |=> !reg_rdata[ST_PROG_EN]) else $error("enable kept");
	busy_done_a: assert property (
		st_rd |=> !(reg_rdata[ST_BUSY] && reg_rdata[ST_DONE])) else $error("busy and done");
	lock_width_a: assert property (
		reg_rd && reg_addr == REG_LOCK |=> reg_rdata[15:2] == 14'h0000) else $error("lock bits");
	op_start_a: assert property (
		(reg_wr && reg_addr == REG_CTRL && reg_wdata[2:0] == CMD_ERASE) ##3 st_rd
		|=> reg_rdata[ST_BUSY] || reg_rdata[ST_DENIED]) else $error("erase not started");
	// main scenarios reached
	cal_c: cover property (cal_rq ##1 par_data_oe);
	done_c: cover property (st_rd ##1 reg_rdata[ST_DONE]);
	deny_c: cover property (st_rd ##1 reg_rdata[ST_DENIED]);
endmodule

bind fpc_top fpc_top_sva #(.CAL_BYTE(CAL_BYTE)) fpc_top_sva_inst (.mclk(mclk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n), .sck(sck), .miso(miso),
	.par_oe_n(par_oe_n), .par_byte_select_one(par_byte_select_one), .par_cmd(par_cmd),
	.par_addr_lo(par_addr_lo), .par_data(par_data), .par_data_oe(par_data_oe));

// file: tb/fpc_prog.sv
// Purpose: behavioural external programmer on the serial interface
// Assumes: 48 ns link base clock, unrelated to the core clock
// Notes:   sck stands low between frames; mosi shows the inverse bit there
`timescale 1ns/10ps
module fpc_prog
(
	output logic      sck,
	output logic      mosi,
	input  wire logic miso
);
	logic lclk = 1'b0;
	// link base clock; sck phases span five of its periods
	always #24 lclk = ~lclk;
	initial
	begin
		sck = 1'b0;
		mosi = 1'b1;
	end
	// 240 ns per phase keeps above two core cycles at 10 MHz
	task automatic phase();
		repeat (5) @(posedge lclk);
	endtask
	// one 32-bit frame, msb first; reply sampled before sck falls
	task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
		for (int i = 31; i >= 0; i--)
		begin
			mosi <= cmd[i];
			phase();
			sck <= 1'b1;
			phase();
			rsp[i] = miso;
			sck <= 1'b0;
		end
		phase();
		mosi <= ~cmd[0];
	endtask
endmodule

// file: tb/fpc_tb_top.sv
// Purpose: self-checking bench for the flash programming control block
// Assumes: register port answers one cycle after the read strobe
// Notes:   flash contents are known only after a serial chip erase, or for one page after a page erase
`timescale 1ns/10ps
module fpc_tb_top;
	import fpc_pkg::*;
	logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        reset_pin_n = 1'b1, par_oe_n = 1'b1, par_bs1 = 1'b0;
	logic        par_data_oe, sck, mosi, miso;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_q;
	logic [7:0]  par_cmd = 8'h00, par_addr_lo = 8'h00, par_data;
	logic [31:0] rsp;
	int          errors = 0, compares = 0;
	// 10 MHz core clock, always present for the serial logic
	always #50 mclk = ~mclk;
	fpc_top fpc_top_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso),
		.par_oe_n(par_oe_n), .par_byte_select_one(par_bs1), .par_cmd(par_cmd),
		.par_addr_lo(par_addr_lo), .par_data(par_data), .par_data_oe(par_data_oe));
	fpc_prog fpc_prog_inst (.sck(sck), .mosi(mosi), .miso(miso));
	// ----------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd_q = reg_rdata;
	endtask
	// flash memory is registered, so one idle cycle after the address
	task automatic rdf(input logic [5:0] a, input logic [15:0] exp);
		wr(REG_ADDR, {10'h000, a});
		@(posedge mclk);
		rd(REG_RDATA);
		chk(rd_q, exp);
	endtask
	task automatic fill(input logic [5:0] a, input logic [15:0] d);
		wr(REG_ADDR, {10'h000, a});
		wr(REG_WDATA, d);
		wr(REG_CTRL, {13'h0000, CMD_FILL});
	endtask
	// refused ops flag at once; accepted ones are polled to done
	task automatic op(input logic [2:0] c, input logic [5:0] a, input logic deny);
		wr(REG_ADDR, {10'h000, a});
		wr(REG_CTRL, {13'h0000, c});
		rd(REG_STATUS);
		for (int i = 0; i < 40 && !deny && rd_q[ST_DONE] !== 1'b1; i++)
			rd(REG_STATUS);
		chk({15'h0000, deny ? rd_q[ST_DENIED] : rd_q[ST_DONE]}, 16'h0001);
	endtask
	// erase frames need the core to sweep memory before the next frame
	task automatic ser(input logic [31:0] c);
		fpc_prog_inst.xfer(c, rsp);
		repeat (100) @(posedge mclk);
	endtask
	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic t_reset();
		rd(REG_LOCK);
		chk(rd_q, 16'h0000);
		ser({SER_PROG_EN, SER_PE_KEY, 16'h0000});
		rd(REG_STATUS);
		chk({15'h0000, rd_q[ST_PROG_EN]}, 16'h0000);
	endtask
	task automatic t_serial();
		reset_pin_n <= 1'b0;
		ser({SER_PROG_EN, SER_PE_KEY, 16'h0000});
		ser({SER_PROG_EN, SER_ERASE_B2, 16'h0000});
		ser({SER_WR_EE, 16'h0005, 8'h3C});
		ser({SER_WR_EE, 16'h0005, 8'hC3});
		ser({SER_RD_EE, 16'h0005, 8'h00});
		ser({SER_RD_EE, 16'h0005, 8'h00});
		chk({8'h00, rsp[7:0]}, 16'h00C3);
		reset_pin_n <= 1'b1;
		repeat (5) @(posedge mclk);
		reset_pin_n <= 1'b0;
		ser({SER_WR_EE, 16'h0006, 8'h11});
		ser({SER_PROG_EN, SER_PE_KEY, 16'h0000});
		ser({SER_RD_EE, 16'h0006, 8'h00});
		ser({SER_RD_EE, 16'h0006, 8'h00});
		chk({8'h00, rsp[7:0]}, {8'h00, ERASED_BYTE});
		reset_pin_n <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask
	task automatic t_flash();
		rdf(6'h0A, 16'hFFFF);
		fill(6'h0D, 16'hABCD);
		fill(6'h0A, 16'h1234);
		rdf(6'h0A, 16'hFFFF);
		op(CMD_ERASE, 6'h08, 1'b0);
		op(CMD_WRITE, 6'h08, 1'b0);
		rdf(6'h0A, 16'h1234);
		rdf(6'h0D, 16'hABCD);
		op(CMD_ERASE, 6'h10, 1'b0);
		fill(6'h11, 16'h5A5A);
		op(CMD_WRITE, 6'h10, 1'b0);
		rdf(6'h11, 16'h5A5A);
	endtask
	task automatic t_lock();
		wr(REG_CTRL, {6'h00, 2'b10, 5'h00, CMD_LOCK});
		rd(REG_LOCK);
		chk(rd_q, 16'h0002);
		op(CMD_ERASE, 6'h28, 1'b1);
		op(CMD_ERASE, 6'h18, 1'b0);
		wr(REG_CTRL, {6'h00, 2'b01, 5'h00, CMD_LOCK});
		rd(REG_LOCK);
		chk(rd_q, 16'h0003);
		op(CMD_ERASE, 6'h18, 1'b1);
		reset_pin_n <= 1'b0;
		ser({SER_PROG_EN, SER_PE_KEY, 16'h0000});
		ser({SER_PROG_EN, SER_ERASE_B2, 16'h0000});
		reset_pin_n <= 1'b1;
		repeat (5) @(posedge mclk);
		rd(REG_LOCK);
		chk(rd_q, 16'h0000);
		rdf(6'h0A, 16'hFFFF);
	endtask
	task automatic t_cal();
		@(posedge mclk);
		par_cmd <= PAR_CMD_CAL;
		par_addr_lo <= PAR_ADDR_CAL;
		par_bs1 <= 1'b1;
		par_oe_n <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk({7'h00, par_data_oe, par_data}, 16'h015A);
		@(posedge mclk);
		par_oe_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk({15'h0000, par_data_oe}, 16'h0000);
	endtask
	task automatic conclude();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// runs well under 1 ms; 2 ms means a hang
	initial
	begin
		#2_000_000;
		errors++;
		conclude();
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_serial();
		t_flash();
		t_lock();
		t_cal();
		conclude();
	end
endmodule
